// *** verilog/watchdog_pkg.sv ***
// Purpose : shared constants and types of the watchdog register block
// Assumes : APB slave, 32-bit data, one 200 MHz clock
// Notes   : register offsets are byte addresses
//
// Overview of operation
// - service key written as one halfword restarts count
// - enable bit runs or stops the watchdog
// - software enable acts only when fuse clear
// - run postscaler shadow loaded from config at reset
// - run clock select shadow loaded at reset
// - sleep postscaler shadow loaded at reset
// - lowest control bit selects windowed mode
// - window enable starts from window-disable config bit
// - clear, set and invert alias addresses
// - bits 14-13 read zero, ignore writes
// - key field resets zero and is write-only
// - missed service before timeout resets the device
// - run or sleep postscaler, low-power clock asleep
// - timeout in sleep or idle wakes device
`default_nettype none

package watchdog_pkg;

    // ========================================================
    // register map
    localparam logic [15:0] CTRL_OFS     = 16'h3E80;
    localparam logic [15:0] CTRL_CLR_OFS = 16'h3E84;
    localparam logic [15:0] CTRL_SET_OFS = 16'h3E88;
    localparam logic [15:0] CTRL_INV_OFS = 16'h3E8C;
    localparam logic [15:0] EVT_OFS      = 16'h3E90;
    localparam logic [15:0] MASK_OFS     = 16'h3E94;

    // ========================================================
    // control register fields
    localparam int          ON_BIT      = 15;
    localparam int          RUNPS_LSB   = 8;
    localparam int          RUNCLK_LSB  = 6;
    localparam int          SLPPS_LSB   = 1;
    localparam int          WINEN_BIT   = 0;
    localparam logic [15:0] SERVICE_KEY = 16'h5743;
    localparam logic [15:0] KEY_RESET   = 16'h0000;
    localparam logic [3:0]  KEY_STRB    = 4'hC;

    // ========================================================
    // event status bits
    localparam int          EVT_W        = 3;
    localparam int          EVT_TIMEOUT  = 0;
    localparam int          EVT_WINDOW   = 1;
    localparam int          EVT_WAKE     = 2;
    localparam logic [2:0]  EVT_RESET    = 3'h0;
    localparam logic [2:0]  MASK_RESET   = 3'h0;

    // ========================================================
    // timing: system tick divider when run clock select is nonzero
    localparam int          SYS_TICK_DIV = 32;
    localparam logic [1:0]  CLK_SEL_LOW_POWER_RC_CLOCK = 2'h0;

    // configuration word fields taken at reset
    typedef struct packed {
        logic       fuse_watchdog_enable;
        logic [4:0] run_postscale_config;
        logic [1:0] run_clock_config;
        logic [4:0] sleep_postscale_config;
        logic       window_disable_config;
    } config_word_s;

    // alias operation chosen by the address
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_CLR   = 2'h1,
        OP_SET   = 2'h2,
        OP_INV   = 2'h3
    } alias_op_e;

    // watchdog state, gray along load -> off -> run
    typedef enum logic [1:0] {
        ST_LOAD = 2'h0,
        ST_OFF  = 2'h1,
        ST_RUN  = 2'h3
    } wd_state_e;

endpackage

`default_nettype wire

// *** verilog/watchdog_counter.sv ***
// Purpose : tick counter with postscaled terminal count and window
// Assumes : tick_in is a one-cycle enable pulse
// Notes   : window opens for the last quarter of the period
`timescale 1ns/1ps
`default_nettype none

module watchdog_counter
    import watchdog_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic       tick_in,
    input  wire logic       restart_in,
    input  wire logic [4:0] postscale_in,
    output logic            timeout_out,
    output logic            window_open_out
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] win_start;
    logic             at_limit;

    if (CNT_W < 32)
    begin : g_chk
        $error("watchdog_counter: CNT_W must cover postscale 31");
    end

    // period is 2^postscale ticks
    assign limit     = (CNT_W'(1) << postscale_in) - CNT_W'(1);
    assign win_start = limit - (limit >> 2);
    assign at_limit  = (count == limit);
    assign window_open_out = (count >= win_start);

    // count ticks, restart on service or timeout
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count       <= '0;
            timeout_out <= 1'b0;
        end
        else
        begin
            timeout_out <= 1'b0;
            if (!run_in || restart_in)
                count <= '0;
            else if (tick_in && at_limit)
            begin
                count       <= '0;
                timeout_out <= 1'b1;
            end
            else if (tick_in)
                count <= count + CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

// *** verilog/watchdog_control_register_block.sv ***
// Purpose : watchdog control register and timeout logic on APB
// Assumes : config word stable at reset release; sleep_in level
// Notes   : pready answers one cycle into the access phase
`timescale 1ns/1ps
`default_nettype none

module watchdog_control_register_block
    import watchdog_pkg::*;
#(
    parameter int TICK_DIV = SYS_TICK_DIV
)
(
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // apb slave
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [15:0]  paddr_in,
    input  wire logic [31:0]  pwdata_in,
    input  wire logic [3:0]   pstrb_in,
    output logic              pready_out,
    output logic [31:0]       prdata_out,
    output logic              pslverr_out,
    // device side
    input  wire config_word_s config_in,
    input  wire logic         sleep_in,
    input  wire logic         low_power_rc_clock_tick_in,
    output logic              reset_request_out,
    output logic              wake_out,
    output logic              irq_out
);

    // ========================================================
    // parameter check
    if (TICK_DIV < 1 || TICK_DIV > 65535)
    begin : g_chk
        $error("TICK_DIV out of range");
    end

    // ========================================================
    // state
    wd_state_e  state;
    wd_state_e  next_state;
    logic       wd_on;
    logic       window_mode_enable;
    logic [4:0] run_postscale_shadow;
    logic [1:0] run_clock_select_shadow;
    logic [4:0] sleep_postscale_shadow;
    logic       fuse_latched;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [15:0] div_cnt;
    logic        sys_tick;

    // ========================================================
    // apb decode
    logic        access;
    logic        wr_take;
    logic        rd_take;
    logic        hit_ctrl;
    logic        hit_evt;
    logic        hit_mask;
    logic        mapped;
    alias_op_e   op;
    logic        key_write;
    logic        service;

    // start of a fresh access phase; pready low marks the first cycle
    assign access   = psel_in && penable_in && !pready_out;
    assign wr_take  = access && pwrite_in;
    assign rd_take  = access && !pwrite_in;

    // address map decoding
    assign hit_ctrl = (paddr_in == CTRL_OFS) || (paddr_in == CTRL_CLR_OFS)
                   || (paddr_in == CTRL_SET_OFS) || (paddr_in == CTRL_INV_OFS);
    assign hit_evt  = (paddr_in == EVT_OFS);
    assign hit_mask = (paddr_in == MASK_OFS);
    assign mapped   = hit_ctrl || hit_evt || hit_mask;

    // alias operation from the full alias address
    always_comb
    begin
        if (paddr_in == CTRL_CLR_OFS)
            op = OP_CLR;
        else if (paddr_in == CTRL_SET_OFS)
            op = OP_SET;
        else if (paddr_in == CTRL_INV_OFS)
            op = OP_INV;
        else
            op = OP_WRITE;
    end

    // key must come as one upper-halfword write at the base address
    assign key_write = wr_take && (paddr_in == CTRL_OFS)
                    && (pstrb_in == KEY_STRB);
    assign service   = key_write
                    && (pwdata_in[31:16] == SERVICE_KEY);

    // ========================================================
    // alias update of one writable bit
    function automatic logic apply_op(
        input logic      cur,
        input logic      dat,
        input logic      lane,
        input alias_op_e kind
    );
        logic res;
        res = cur;
        if (lane)
        begin
            case (kind)
                OP_WRITE: res = dat;
                OP_CLR:   res = cur & ~dat;
                OP_SET:   res = cur | dat;
                OP_INV:   res = cur ^ dat;
                default:  res = cur;
            endcase
        end
        return res;
    endfunction

    logic next_on;
    logic next_winen;
    logic ctrl_wr;

    // only bits 15 and 0 are writable; others ignore writes
    assign ctrl_wr    = wr_take && hit_ctrl && (state != ST_LOAD);
    assign next_on    = ctrl_wr
                      ? apply_op(wd_on, pwdata_in[ON_BIT],
                                 pstrb_in[1], op)
                      : wd_on;
    assign next_winen = ctrl_wr
                      ? apply_op(window_mode_enable,
                                 pwdata_in[WINEN_BIT], pstrb_in[0], op)
                      : window_mode_enable;

    // ========================================================
    // effective enable: fuse forces run, else software bit
    logic run_enable;
    assign run_enable = fuse_latched || wd_on;

    // next state of the watchdog
    always_comb
    begin
        next_state = state;
        case (state)
            ST_LOAD: next_state = ST_OFF;
            ST_OFF:  if (run_enable) next_state = ST_RUN;
            ST_RUN:  if (!run_enable) next_state = ST_OFF;
            default: next_state = ST_LOAD;
        endcase
    end

    // state register
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            state <= ST_LOAD;
        else
            state <= next_state;
    end

    // ========================================================
    // shadow fields taken from the config word after reset release
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            run_postscale_shadow    <= '0;
            run_clock_select_shadow <= '0;
            sleep_postscale_shadow  <= '0;
            fuse_latched            <= 1'b0;
        end
        else if (state == ST_LOAD)
        begin
            run_postscale_shadow    <= config_in.run_postscale_config;
            run_clock_select_shadow <= config_in.run_clock_config;
            sleep_postscale_shadow  <= config_in.sleep_postscale_config;
            fuse_latched            <= config_in.fuse_watchdog_enable;
        end
    end

    // control bits: software enable and window mode
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wd_on              <= 1'b0;
            window_mode_enable <= 1'b0;
        end
        else if (state == ST_LOAD)
        begin
            wd_on              <= 1'b0;
            window_mode_enable <= config_in.window_disable_config;
        end
        else
        begin
            wd_on              <= next_on;
            window_mode_enable <= next_winen;
        end
    end

    // ========================================================
    // tick source: low-power clock asleep or when selected
    logic div_wrap;
    logic tick;
    logic [4:0] postscale;

    assign div_wrap = (div_cnt == 16'(TICK_DIV - 1));

    // system clock divider for run-mode ticks
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_cnt  <= '0;
            sys_tick <= 1'b0;
        end
        else
        begin
            div_cnt  <= div_wrap ? 16'h0000 : div_cnt + 16'h0001;
            sys_tick <= div_wrap;
        end
    end

    // choose clock and postscaler by power mode
    assign tick = (sleep_in || run_clock_select_shadow == CLK_SEL_LOW_POWER_RC_CLOCK)
                ? low_power_rc_clock_tick_in : sys_tick;
    assign postscale = sleep_in ? sleep_postscale_shadow
                                : run_postscale_shadow;

    // ========================================================
    // counter
    logic timeout;
    logic window_open;
    logic early_service;
    logic violation;

    watchdog_counter #(
        .CNT_W (32)
    ) u_counter (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .run_in          (state == ST_RUN),
        .tick_in         (tick),
        .restart_in      (service),
        .postscale_in    (postscale),
        .timeout_out     (timeout),
        .window_open_out (window_open)
    );

    // in windowed mode, service before the window opens counts as a violation
    assign early_service = service && (state == ST_RUN)
                        && window_mode_enable && !window_open;
    assign violation = (timeout || early_service);

    // ========================================================
    // reset request in run, wake in sleep or idle
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reset_request_out <= 1'b0;
            wake_out          <= 1'b0;
        end
        else
        begin
            reset_request_out <= violation && !sleep_in;
            wake_out          <= timeout && sleep_in;
        end
    end

    // ========================================================
    // sticky events, write one to clear, set wins
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    assign evt_set[EVT_TIMEOUT] = timeout && !sleep_in;
    assign evt_set[EVT_WINDOW]  = early_service;
    assign evt_set[EVT_WAKE]    = timeout && sleep_in;
    assign evt_clr = (wr_take && hit_evt && pstrb_in[0])
                   ? pwdata_in[EVT_W-1:0] : '0;

    // event status and mask registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            evt  <= EVT_RESET;
            mask <= MASK_RESET;
        end
        else
        begin
            evt <= (evt & ~evt_clr) | evt_set;
            if (wr_take && hit_mask && pstrb_in[0])
                mask <= pwdata_in[EVT_W-1:0];
        end
    end

    // level interrupt from unmasked events
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(((evt & ~evt_clr) | evt_set) & mask);
    end

    // ========================================================
    // read data mux; key field reads zero, bits 14-13 zero
    logic [31:0] ctrl_rd;
    logic [31:0] rd_mux;

    assign ctrl_rd = {KEY_RESET, wd_on, 2'h0,
                      run_postscale_shadow, run_clock_select_shadow,
                      sleep_postscale_shadow,
                      window_mode_enable};

    always_comb
    begin
        if (hit_ctrl)
            rd_mux = ctrl_rd;
        else if (hit_evt)
            rd_mux = {29'h0, evt};
        else if (hit_mask)
            rd_mux = {29'h0, mask};
        else
            rd_mux = 32'h0;
    end

    // apb answer: one wait cycle, then pready with data
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= access;
            pslverr_out <= access && !mapped;
            prdata_out  <= rd_take ? rd_mux : 32'h0;
        end
    end

endmodule

`default_nettype wire

// *** sim/watchdog_properties.sv ***
// Purpose : concurrent checks on the watchdog register block ports
// Assumes : one clock domain, reset active high
// Notes   : bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none

module watchdog_properties
    import watchdog_pkg::*;
#(
    parameter int TICK_DIV = SYS_TICK_DIV
)
(
    input wire logic         clk_in,
    input wire logic         rst_in,
    input wire logic         psel_in,
    input wire logic         penable_in,
    input wire logic         pwrite_in,
    input wire logic [15:0]  paddr_in,
    input wire logic [31:0]  pwdata_in,
    input wire logic [3:0]   pstrb_in,
    input wire logic         pready_out,
    input wire logic [31:0]  prdata_out,
    input wire logic         pslverr_out,
    input wire config_word_s config_in,
    input wire logic         sleep_in,
    input wire logic         low_power_rc_clock_tick_in,
    input wire logic         reset_request_out,
    input wire logic         wake_out,
    input wire logic         irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ========================================================
    // read answer of the control register
    wire logic ctrl_read;
    assign ctrl_read = pready_out && !pwrite_in && paddr_in == CTRL_OFS;

    // ========================================================
    // bus handshake and read data
    ready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("access phase not answered after one wait");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
        else $error("ready without a waiting access");
    err_data_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error answer carries data");
    ctrl_zero_a: assert property (ctrl_read |-> prdata_out[31:16] == 16'h0 && prdata_out[14:13] == 2'h0)
        else $error("key or unused bits read nonzero");
    shadow_read_a: assert property (ctrl_read |-> prdata_out[12:1] == {config_in.run_postscale_config,
        config_in.run_clock_config, config_in.sleep_postscale_config})
        else $error("shadow fields differ from config");

    // ========================================================
    // violation and wake pulses
    event_excl_a: assert property (reset_request_out |-> !wake_out)
        else $error("reset request and wake together");
    req_pulse_a: assert property (reset_request_out |=> !reset_request_out)
        else $error("reset request longer than one cycle");
    wake_pulse_a: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");

    cover property (ctrl_read);
    cover property (reset_request_out);
    cover property (wake_out);
    cover property (pslverr_out);
endmodule

bind watchdog_control_register_block watchdog_properties #(.TICK_DIV(TICK_DIV)) i_props (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .config_in(config_in), .sleep_in(sleep_in), .low_power_rc_clock_tick_in(low_power_rc_clock_tick_in),
    .reset_request_out(reset_request_out), .wake_out(wake_out), .irq_out(irq_out));

`default_nettype wire

// *** sim/testbench.sv ***
// Purpose : self-checking bench of the watchdog register block
// Assumes : bus master waits for pready; tick divider set to 4
// Notes   : all inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none

module testbench import watchdog_pkg::*;;
    logic         clk_in = 1'b0;
    logic         rst_in = 1'b1;
    logic         psel_in = 1'b0;
    logic         penable_in = 1'b0;
    logic         pwrite_in = 1'b0;
    logic [15:0]  paddr_in = 16'h0;
    logic [31:0]  pwdata_in = 32'h0;
    logic [3:0]   pstrb_in = 4'h0;
    config_word_s config_in = '0;
    logic         sleep_in = 1'b0;
    logic         low_power_rc_clock_tick_in = 1'b0;
    logic         pready_out;
    logic [31:0]  prdata_out;
    logic         pslverr_out;
    logic         reset_request_out;
    logic         wake_out;
    logic         irq_out;
    logic [31:0]  rd;
    logic         er;
    logic         tick_on = 1'b0;
    logic [1:0]   phase = 2'h0;
    int           error_cnt = 0;
    int           checks = 0;
    int           req_n = 0;
    int           wake_n = 0;
    int           base;
    int           wbase;
    localparam logic [15:0] ALIAS [4] = '{CTRL_SET_OFS, CTRL_CLR_OFS, CTRL_INV_OFS, CTRL_INV_OFS};
    localparam logic        WIN [4]   = '{1'b1, 1'b0, 1'b1, 1'b0};
    localparam logic [15:0] KEYS [3]  = '{SERVICE_KEY, 16'h5742, SERVICE_KEY};
    localparam logic [3:0]  STRBS [3] = '{KEY_STRB, KEY_STRB, 4'hF};

    always #2.5 clk_in = ~clk_in;

    watchdog_control_register_block #(.TICK_DIV(4)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pstrb_in(pstrb_in), .pready_out(pready_out), .prdata_out(prdata_out),
        .pslverr_out(pslverr_out), .config_in(config_in), .sleep_in(sleep_in),
        .low_power_rc_clock_tick_in(low_power_rc_clock_tick_in), .reset_request_out(reset_request_out),
        .wake_out(wake_out), .irq_out(irq_out));

    // ========================================================
    // count pulses and make the slow tick every fourth cycle
    always @(posedge clk_in)
    begin
        if (reset_request_out === 1'b1)
            req_n <= req_n + 1;
        if (wake_out === 1'b1)
            wake_n <= wake_n + 1;
        phase <= phase + 2'h1;
        low_power_rc_clock_tick_in <= tick_on && phase == 2'h0;
    end

    // ========================================================
    // compare, bus and reset tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        pstrb_in   <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // only the watchdog process ends a wait that never sees pready
        do
        begin
            @(posedge clk_in);
        end
        while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic do_reset(input config_word_s c);
        config_in <= c;
        rst_in    <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    function automatic logic [31:0] exp_ctrl(input logic on, input logic win);
        return {16'h0000, on, 2'h0, config_in.run_postscale_config,
                config_in.run_clock_config, config_in.sleep_postscale_config, win};
    endfunction

    task automatic end_sim();
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ========================================================
    // cuts a hung run short
    initial
    begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        end_sim();
    end

    // ========================================================
    // main sequence
    initial
    begin
        do_reset('{1'b0, 5'h02, 2'h1, 5'h01, 1'b0});
        xfer(1'b0, CTRL_OFS, 32'h0, 4'h0);
        chk_word(rd, exp_ctrl(1'b0, 1'b0));
        base = req_n;
        repeat (60) @(posedge clk_in);
        chk_word(32'(req_n - base), 32'h0);
        xfer(1'b1, CTRL_OFS, 32'hFFFF_7FFE, 4'hF);
        xfer(1'b0, CTRL_OFS, 32'h0, 4'h0);
        chk_word(rd, exp_ctrl(1'b0, 1'b0));
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, ALIAS[i], 32'h0000_0001, 4'h1);
            xfer(1'b0, CTRL_OFS, 32'h0, 4'h0);
            chk_word(rd, exp_ctrl(1'b0, WIN[i]));
        end
        // good key, wrong key, key written as a full word
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b1, CTRL_OFS, 32'h0000_8000, 4'h3);
            base = req_n;
            repeat (10) xfer(1'b1, CTRL_OFS, {KEYS[k], 16'h8000}, STRBS[k]);
            chk_word(32'(req_n > base), {31'h0, k != 0});
            xfer(1'b1, CTRL_OFS, 32'h0, 4'h3);
        end
        xfer(1'b0, EVT_OFS, 32'h0, 4'h0);
        chk_word(rd, 32'h1);
        chk_word({31'h0, irq_out}, 32'h0);
        xfer(1'b1, MASK_OFS, 32'h1, 4'h1);
        @(posedge clk_in);
        chk_word({31'h0, irq_out}, 32'h1);
        xfer(1'b1, EVT_OFS, 32'h7, 4'h1);
        xfer(1'b0, EVT_OFS, 32'h0, 4'h0);
        chk_word(rd, 32'h0);
        chk_word({31'h0, irq_out}, 32'h0);
        // early service in windowed mode
        xfer(1'b1, CTRL_OFS, 32'h0000_8001, 4'h3);
        base = req_n;
        xfer(1'b1, CTRL_OFS, {SERVICE_KEY, 16'h0}, KEY_STRB);
        repeat (2) @(posedge clk_in);
        chk_word(32'(req_n - base), 32'h1);
        xfer(1'b0, EVT_OFS, 32'h0, 4'h0);
        chk_word(rd, 32'h2);
        xfer(1'b1, CTRL_OFS, 32'h0, 4'h3);
        xfer(1'b1, EVT_OFS, 32'h7, 4'h1);
        // asleep: slow tick, sleep postscaler, wake only
        sleep_in <= 1'b1;
        tick_on  <= 1'b1;
        xfer(1'b1, CTRL_OFS, 32'h0000_8000, 4'h3);
        base  = req_n;
        wbase = wake_n;
        repeat (60) @(posedge clk_in);
        chk_word(32'(req_n - base), 32'h0);
        chk_word(32'(wake_n - wbase >= 5), 32'h1);
        xfer(1'b1, CTRL_OFS, 32'h0, 4'h3);
        sleep_in <= 1'b0;
        tick_on  <= 1'b0;
        xfer(1'b0, 16'h3E98, 32'h0, 4'h0);
        chk_word(rd, 32'h0);
        chk_word({31'h0, er}, 32'h1);
        // fuse set, run clock from the slow tick: runs with enable bit zero
        do_reset('{1'b1, 5'h02, 2'h0, 5'h01, 1'b1});
        xfer(1'b0, CTRL_OFS, 32'h0, 4'h0);
        chk_word(rd, exp_ctrl(1'b0, 1'b1));
        base = req_n;
        repeat (60) @(posedge clk_in);
        chk_word(32'(req_n - base), 32'h0);
        tick_on <= 1'b1;
        base = req_n;
        repeat (60) @(posedge clk_in);
        chk_word(32'(req_n > base), 32'h1);
        end_sim();
    end
endmodule

`default_nettype wire
